/* File: dmb_addr_map.sv */
`timescale 1ns/1ps
// Address resolver: turns a named address into an effective address and bank.
// Assumes the pointers are already masked for the variant in use.
module dmb_addr_map (
    input  wire logic [7:0] addr,
    input  wire logic [7:0] ptr0,
    input  wire logic [7:0] ptr1,
    input  wire logic       bank_one,
    output logic      [7:0] eff_addr,
    output logic            eff_bank,
    output logic            eff_null
);
    // Window references take the pointer as address, same cycle as direct
    always_comb begin
        eff_addr = addr;
        eff_bank = 1'b0;
        eff_null = 1'b0;
        if (addr == dmb_pkg::ADR_WIN0) begin
            eff_addr = ptr0;
            eff_bank = 1'b0;
        end else if (addr == dmb_pkg::ADR_WIN1) begin
            eff_addr = ptr1;
            eff_bank = bank_one;
        end
        // Windows are not physical, so aiming a pointer at one goes nowhere
        if ((addr == dmb_pkg::ADR_WIN0 || addr == dmb_pkg::ADR_WIN1) &&
            (eff_addr == dmb_pkg::ADR_WIN0 ||
             eff_addr == dmb_pkg::ADR_WIN1)) begin
            eff_null = 1'b1;
        end
    end
endmodule // dmb_addr_map

/* File: dmb_bank.sv */
`timescale 1ns/1ps
// Data memory bank with special registers, indirect windows and bank pointer.
// Assumes the execution unit issues at most one read or write per cycle and
// that the ALU result arrives on ALU_RESULT with ALU_VALID.
module dmb_bank #(
    parameter int  SFR_END   = 8'h20,
    parameter int  GPR_START = 8'h40,
    parameter int  GPR_WORDS = 192,
    parameter int  PC_WIDTH  = 11,
    parameter bit  SMALL_RAM = 1'b1
) (
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic                WDT_PD_RESET,
    input  wire logic [7:0]          ADDR,
    input  wire logic                RD_EN,
    input  wire logic                WR_EN,
    input  wire logic [7:0]          WR_DATA,
    input  wire logic                ALU_VALID,
    input  wire logic [7:0]          ALU_RESULT,
    input  wire logic                PC_ADVANCE,
    output logic      [7:0]          RD_DATA,
    output logic      [7:0]          ACC_OUT,
    output logic      [7:0]          EE_CTRL_OUT,
    output logic                     EE_CTRL_WR,
    output logic                     BANK_ONE,
    output logic      [PC_WIDTH-1:0] PC_OUT,
    output logic                     DUMMY_CYCLE
);
    logic [7:0] ptr0_reg;
    logic [7:0] ptr1_reg;
    logic [7:0] bank_reg;
    logic [7:0] acc_reg;
    logic [7:0] eeprom_control_window_reg;
    logic [7:0] rd_next;
    logic [7:0] eff_addr;
    logic       eff_bank;
    logic       eff_null;
    logic [7:0] ptr0_view;
    logic [7:0] ptr1_view;
    logic [7:0] gpr_mem [GPR_WORDS];
    logic       wr_ok;
    logic       pcl_write;

    // Pointer top bit: a constant one on small variants
    function automatic logic [7:0] ptr_view(input logic [7:0] v);
        return SMALL_RAM ? (v | dmb_pkg::PTR_TOPBIT) : v;
    endfunction

    // True when the address lies in general memory
    function automatic logic in_gpr(input logic [7:0] a);
        return (a >= 8'(GPR_START)) &&
               (int'(a) < GPR_START + GPR_WORDS);
    endfunction

    assign ptr0_view = ptr_view(ptr0_reg);
    assign ptr1_view = ptr_view(ptr1_reg);

    dmb_addr_map u_map (
        .addr     (ADDR),
        .ptr0     (ptr0_view),
        .ptr1     (ptr1_view),
        .bank_one (BANK_ONE),
        .eff_addr (eff_addr),
        .eff_bank (eff_bank),
        .eff_null (eff_null)
    );

    assign BANK_ONE  = (bank_reg == dmb_pkg::BANK1_VAL);
    assign wr_ok     = WR_EN && !eff_null;
    assign pcl_write = wr_ok && !eff_bank &&
                       eff_addr == dmb_pkg::ADR_PCL;

    // Memory pointers are ordinary writable storage
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ptr0_reg <= dmb_pkg::ZERO_BYTE;
            ptr1_reg <= dmb_pkg::ZERO_BYTE;
        end else if (wr_ok && !eff_bank) begin
            if (eff_addr == dmb_pkg::ADR_PTR0) begin
                ptr0_reg <= WR_DATA;
            end
            if (eff_addr == dmb_pkg::ADR_PTR1) begin
                ptr1_reg <= WR_DATA;
            end
        end
    end

    // Bank pointer survives only a watchdog reset taken in power-down.
    // That reset must come in as WDT_PD_RESET, never as RST.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bank_reg <= dmb_pkg::BANK0_VAL;
        end else if (WDT_PD_RESET) begin
            bank_reg <= bank_reg;
        end else if (wr_ok && !eff_bank &&
                     eff_addr == dmb_pkg::ADR_BANK) begin
            bank_reg <= WR_DATA;
        end
    end

    // Accumulator takes every ALU result; a bus write loads it only in a cycle without ALU_VALID
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            acc_reg <= dmb_pkg::ZERO_BYTE;
        end else if (ALU_VALID) begin
            acc_reg <= ALU_RESULT;
        end else if (wr_ok && !eff_bank &&
                     eff_addr == dmb_pkg::ADR_ACC) begin
            acc_reg <= WR_DATA;
        end
    end

    // EEPROM control lives alone in bank 1; direct address cannot reach it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            eeprom_control_window_reg   <= dmb_pkg::ZERO_BYTE;
            EE_CTRL_WR <= 1'b0;
        end else begin
            EE_CTRL_WR <= 1'b0;
            if (wr_ok && eff_bank && eff_addr == dmb_pkg::ADR_EEPROM_CONTROL_WINDOW) begin
                eeprom_control_window_reg   <= WR_DATA;
                EE_CTRL_WR <= 1'b1;
            end
        end
    end

    // General memory exists in bank 0 only; bank 1 writes elsewhere drop
    always_ff @(posedge CLK) begin
        if (wr_ok && !eff_bank && in_gpr(eff_addr)) begin
            gpr_mem[int'(eff_addr) - GPR_START] <= WR_DATA;
        end
    end

    // Read mux: special area decoded in bank 0 only; bank 1 decodes just EEPROM control
    always_comb begin
        rd_next = dmb_pkg::ZERO_BYTE;
        if (eff_null) begin
            rd_next = dmb_pkg::ZERO_BYTE;
        end else if (eff_bank) begin
            if (eff_addr == dmb_pkg::ADR_EEPROM_CONTROL_WINDOW) begin
                rd_next = eeprom_control_window_reg;
            end
        end else if (eff_addr < 8'(SFR_END)) begin
            case (eff_addr)
                dmb_pkg::ADR_PTR0: rd_next = ptr0_view;
                dmb_pkg::ADR_PTR1: rd_next = ptr1_view;
                dmb_pkg::ADR_BANK: rd_next = bank_reg;
                dmb_pkg::ADR_ACC:  rd_next = acc_reg;
                dmb_pkg::ADR_PCL:  rd_next = PC_OUT[7:0];
                default:           rd_next = dmb_pkg::ZERO_BYTE;
            endcase
        end else if (in_gpr(eff_addr)) begin
            rd_next = gpr_mem[int'(eff_addr) - GPR_START];
        end
    end

    // Read data registered so direct and indirect reads have equal latency
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RD_DATA <= dmb_pkg::ZERO_BYTE;
        end else if (RD_EN) begin
            RD_DATA <= rd_next;
        end
    end

    assign ACC_OUT     = acc_reg;
    assign EE_CTRL_OUT = eeprom_control_window_reg;

    dmb_pc_low #(
        .PC_WIDTH (PC_WIDTH)
    ) u_pcl (
        .CLK         (CLK),
        .RST         (RST),
        .pcl_write   (pcl_write),
        .pcl_wdata   (WR_DATA),
        .pc_advance  (PC_ADVANCE),
        .pc_reg      (PC_OUT),
        .dummy_cycle (DUMMY_CYCLE)
    );

    // Checks
    sequence s_win1_bank1_wr;
        ADDR == dmb_pkg::ADR_WIN1 && WR_EN && BANK_ONE &&
        ptr1_view == dmb_pkg::ADR_EEPROM_CONTROL_WINDOW;
    endsequence

    AST_EEPROM_CONTROL_WINDOW_REACH: assert property (@(posedge CLK) disable iff (RST)
        s_win1_bank1_wr |=> EE_CTRL_WR && EE_CTRL_OUT == $past(WR_DATA))
        else $error("EEPROM control not written via window one");
    AST_EEPROM_CONTROL_WINDOW_DIRECT: assert property (@(posedge CLK) disable iff (RST)
        (ADDR == dmb_pkg::ADR_EEPROM_CONTROL_WINDOW && WR_EN) |=> !EE_CTRL_WR)
        else $error("Direct address reached bank 1");
    AST_WIN0_BANK0: assert property (@(posedge CLK) disable iff (RST)
        (ADDR == dmb_pkg::ADR_WIN0 && WR_EN) |=> !EE_CTRL_WR)
        else $error("Window zero reached bank 1");
    AST_NULL_READ: assert property (@(posedge CLK) disable iff (RST)
        (RD_EN && eff_null) |=> RD_DATA == dmb_pkg::ZERO_BYTE)
        else $error("Window self read not zero");
    AST_PTR_TOP: assert property (@(posedge CLK) disable iff (RST)
        (RD_EN && ADDR == dmb_pkg::ADR_PTR0 && SMALL_RAM) |=>
        RD_DATA[dmb_pkg::TOP_BIT])
        else $error("Pointer top bit not read as one");
    AST_PTR_WR: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == dmb_pkg::ADR_PTR1) |=> ptr1_reg == $past(WR_DATA))
        else $error("Pointer one write lost");
    AST_BANK_HOLD: assert property (@(posedge CLK) disable iff (RST)
        WDT_PD_RESET |=> $stable(bank_reg))
        else $error("Bank changed on power-down watchdog reset");
    AST_ACC_ALU: assert property (@(posedge CLK) disable iff (RST)
        ALU_VALID |=> ACC_OUT == $past(ALU_RESULT))
        else $error("ALU result not in accumulator");
    AST_SFR_BANK: assert property (@(posedge CLK) disable iff (RST)
        (RD_EN && ADDR == dmb_pkg::ADR_BANK) |=> RD_DATA == bank_reg)
        else $error("Special register read depends on bank");
    AST_BANK_SEL: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == dmb_pkg::ADR_BANK && !WDT_PD_RESET) |=>
        BANK_ONE == ($past(WR_DATA) == dmb_pkg::BANK1_VAL))
        else $error("Bank select decode wrong");
endmodule // dmb_bank

/* File: dmb_bank_tb_top.sv */
// Self-checking bench for the data memory bank and indirect access block.
// Assumes dmb_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module dmb_bank_tb_top;
    logic        CLK, RST, WDT_PD_RESET, RD_EN, WR_EN, ALU_VALID, PC_ADVANCE;
    logic [7:0]  ADDR, WR_DATA, ALU_RESULT, RD_DATA, ACC_OUT, EE_CTRL_OUT;
    logic [7:0]  rd_small;
    logic        EE_CTRL_WR, BANK_ONE, DUMMY_CYCLE;
    logic [10:0] PC_OUT;
    int          fails = 0;
    int          n_tests = 0;

    // Full-width variant carries every scenario
    dmb_bank #(.SMALL_RAM(1'b0)) u_dut (
        .CLK(CLK), .RST(RST), .WDT_PD_RESET(WDT_PD_RESET), .ADDR(ADDR),
        .RD_EN(RD_EN), .WR_EN(WR_EN), .WR_DATA(WR_DATA),
        .ALU_VALID(ALU_VALID), .ALU_RESULT(ALU_RESULT),
        .PC_ADVANCE(PC_ADVANCE), .RD_DATA(RD_DATA), .ACC_OUT(ACC_OUT),
        .EE_CTRL_OUT(EE_CTRL_OUT), .EE_CTRL_WR(EE_CTRL_WR),
        .BANK_ONE(BANK_ONE), .PC_OUT(PC_OUT), .DUMMY_CYCLE(DUMMY_CYCLE)
    );

    // Small variant shares stimulus; only its pointer readback is judged
    dmb_bank #(.SMALL_RAM(1'b1)) u_small (
        .CLK(CLK), .RST(RST), .WDT_PD_RESET(WDT_PD_RESET), .ADDR(ADDR),
        .RD_EN(RD_EN), .WR_EN(WR_EN), .WR_DATA(WR_DATA),
        .ALU_VALID(ALU_VALID), .ALU_RESULT(ALU_RESULT),
        .PC_ADVANCE(PC_ADVANCE), .RD_DATA(rd_small), .ACC_OUT(),
        .EE_CTRL_OUT(), .EE_CTRL_WR(), .BANK_ONE(), .PC_OUT(),
        .DUMMY_CYCLE()
    );

    // Core clock, 25 ns period
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    // Case equality so an unknown never passes
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bus tasks enter and leave at a falling edge, one strobe cycle each
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR = a;
        WR_DATA = d;
        WR_EN = 1'b1;
        @(negedge CLK);
        WR_EN = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        ADDR = a;
        RD_EN = 1'b1;
        @(negedge CLK);
        RD_EN = 1'b0;
        chk(RD_DATA, exp); // Expectation tagged by each caller
    endtask

    // Reserved gap between special and general memory
    task automatic t_unused;
        chk({BANK_ONE, DUMMY_CYCLE}, 2'h0);
        rd(8'h20, 8'h00);
        rd(8'h3F, 8'h00);
        rd(dmb_pkg::ADR_BANK, dmb_pkg::BANK0_VAL);
    endtask

    // Pointers are real storage; small variant forces bit 7
    task automatic t_ptr;
        wr(dmb_pkg::ADR_PTR0, 8'h12);
        rd(dmb_pkg::ADR_PTR0, 8'h12);
        chk(rd_small, 8'h92);
        wr(dmb_pkg::ADR_PTR1, 8'hF3);
        rd(dmb_pkg::ADR_PTR1, 8'hF3);
        chk(rd_small, 8'hF3);
    endtask

    // Window accesses land on the pointed location, same timing as direct
    task automatic t_ind;
        wr(8'h50, 8'hA5);
        wr(dmb_pkg::ADR_PTR0, 8'h50);
        rd(dmb_pkg::ADR_WIN0, 8'hA5);
        wr(dmb_pkg::ADR_WIN0, 8'h3C);
        rd(8'h50, 8'h3C);
        rd(dmb_pkg::ADR_PTR0, 8'h50);
        wr(dmb_pkg::ADR_PTR1, 8'h50);
        rd(dmb_pkg::ADR_WIN1, 8'h3C);
    endtask

    // A pointer aimed at a window must not chain into the other pointer
    task automatic t_self;
        wr(8'h60, 8'h11);
        wr(dmb_pkg::ADR_PTR1, 8'h60);
        wr(dmb_pkg::ADR_PTR0, dmb_pkg::ADR_WIN1);
        rd(dmb_pkg::ADR_WIN0, 8'h00);
        wr(dmb_pkg::ADR_WIN0, 8'h99);
        rd(8'h60, 8'h11);
        wr(dmb_pkg::ADR_PTR1, dmb_pkg::ADR_WIN0);
        wr(dmb_pkg::ADR_PTR0, 8'h60);
        wr(dmb_pkg::ADR_WIN1, 8'h77);
        rd(8'h60, 8'h11);
        rd(dmb_pkg::ADR_WIN1, 8'h00);
    endtask

    // Bank one holds only the EEPROM control byte behind window one
    task automatic t_bank;
        wr(8'h40, 8'h77);
        wr(dmb_pkg::ADR_BANK, dmb_pkg::BANK1_VAL);
        chk(BANK_ONE, 1'b1);
        rd(dmb_pkg::ADR_BANK, dmb_pkg::BANK1_VAL);
        wr(dmb_pkg::ADR_PTR1, 8'h50);
        rd(dmb_pkg::ADR_WIN1, 8'h00);
        wr(dmb_pkg::ADR_PTR1, dmb_pkg::ADR_EEPROM_CONTROL_WINDOW);
        wr(dmb_pkg::ADR_WIN1, 8'h5A);
        chk({EE_CTRL_OUT, EE_CTRL_WR}, {8'h5A, 1'b1});
        @(negedge CLK);
        chk(EE_CTRL_WR, 1'b0);
        rd(dmb_pkg::ADR_WIN1, 8'h5A);
        rd(dmb_pkg::ADR_EEPROM_CONTROL_WINDOW, 8'h77);
        wr(dmb_pkg::ADR_PTR0, dmb_pkg::ADR_EEPROM_CONTROL_WINDOW);
        rd(dmb_pkg::ADR_WIN0, 8'h77);
        wr(dmb_pkg::ADR_WIN0, 8'h66);
        chk(EE_CTRL_OUT, 8'h5A);
        rd(8'h40, 8'h66);
        wr(dmb_pkg::ADR_BANK, 8'h02);
        rd(dmb_pkg::ADR_WIN1, 8'h66);
        wr(dmb_pkg::ADR_BANK, dmb_pkg::BANK0_VAL);
        rd(dmb_pkg::ADR_WIN1, 8'h66);
    endtask

    // Watchdog wake keeps the bank; a full reset in mid-run clears it
    task automatic t_resets;
        wr(dmb_pkg::ADR_BANK, dmb_pkg::BANK1_VAL);
        WDT_PD_RESET = 1'b1;
        @(negedge CLK);
        WDT_PD_RESET = 1'b0;
        chk(BANK_ONE, 1'b1);
        RST = 1'b1;
        @(negedge CLK);
        chk({BANK_ONE, EE_CTRL_OUT}, 9'h000);
        RST = 1'b0;
        @(negedge CLK);
        rd(dmb_pkg::ADR_BANK, dmb_pkg::BANK0_VAL);
    endtask

    // ALU result beats a bus write landing in the same cycle
    task automatic t_acc;
        ALU_RESULT = 8'h3E;
        ALU_VALID = 1'b1;
        @(negedge CLK);
        ALU_VALID = 1'b0;
        chk(ACC_OUT, 8'h3E);
        rd(dmb_pkg::ADR_ACC, 8'h3E);
        ALU_RESULT = 8'hC1;
        ALU_VALID = 1'b1;
        wr(dmb_pkg::ADR_ACC, 8'h24);
        ALU_VALID = 1'b0;
        chk(ACC_OUT, 8'hC1);
        wr(dmb_pkg::ADR_ACC, 8'h24);
        chk(ACC_OUT, 8'h24);
    endtask

    // Page-local jump, then the inserted cycle swallows one advance
    task automatic t_pcl;
        PC_ADVANCE = 1'b1;
        repeat (260) @(negedge CLK);
        PC_ADVANCE = 1'b0;
        chk(PC_OUT, 11'h104);
        wr(dmb_pkg::ADR_PCL, 8'h20);
        chk({PC_OUT, DUMMY_CYCLE}, {11'h120, 1'b1});
        PC_ADVANCE = 1'b1;
        @(negedge CLK);
        chk({PC_OUT, DUMMY_CYCLE}, {11'h120, 1'b0});
        @(negedge CLK);
        PC_ADVANCE = 1'b0;
        chk(PC_OUT, 11'h121);
    endtask

    // Single ending point for both the sequence and the watchdog
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Run is near 326 cycles; about fourteen times that (4500) means a hang
    initial begin
        #(25 * 4500);
        fails++;
        close_out();
    end

    // Main sequence: ten cycles of reset, then each scenario in turn
    initial begin
        RST = 1'b1;
        WDT_PD_RESET = 1'b0;
        RD_EN = 1'b0;
        WR_EN = 1'b0;
        ADDR = 8'h00;
        WR_DATA = 8'h00;
        ALU_VALID = 1'b0;
        ALU_RESULT = 8'h00;
        PC_ADVANCE = 1'b0;
        repeat (10) @(negedge CLK);
        RST = 1'b0;
        t_unused();
        t_ptr();
        t_ind();
        t_self();
        t_bank();
        t_resets();
        t_acc();
        t_pcl();
        close_out();
    end
endmodule // dmb_bank_tb_top

/* File: dmb_pc_low.sv */
`timescale 1ns/1ps
// Program counter low byte register with page-local jump and dummy cycle.
// Assumes the sequencer holds fetch while DUMMY_CYCLE is high.
module dmb_pc_low #(
    parameter int PC_WIDTH = 11
) (
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic                pcl_write,
    input  wire logic [7:0]          pcl_wdata,
    input  wire logic                pc_advance,
    output logic      [PC_WIDTH-1:0] pc_reg,
    output logic                     dummy_cycle
);
    dmb_pkg::dmb_state_t state_reg;

    // Write keeps the upper page bits, so the jump never leaves the page
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pc_reg <= '0;
        end else if (pcl_write) begin
            pc_reg <= {pc_reg[PC_WIDTH-1:8], pcl_wdata};
        end else if (pc_advance && state_reg == dmb_pkg::DMB_RUN) begin
            pc_reg <= pc_reg + 1'b1;
        end
    end

    // One inserted cycle after each low-byte write made outside a dummy cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= dmb_pkg::DMB_RUN;
        end else begin
            case (state_reg)
                dmb_pkg::DMB_RUN:   if (pcl_write) begin
                    state_reg <= dmb_pkg::DMB_DUMMY;
                end
                dmb_pkg::DMB_DUMMY: state_reg <= dmb_pkg::DMB_RUN;
                default:            state_reg <= dmb_pkg::DMB_RUN;
            endcase
        end
    end

    assign dummy_cycle = (state_reg == dmb_pkg::DMB_DUMMY);

    AST_PCL_DUMMY: assert property (@(posedge CLK) disable iff (RST)
        (pcl_write && !dummy_cycle) |=> dummy_cycle ##1 !dummy_cycle)
        else $error("Dummy cycle missing after low byte write");
    AST_PCL_PAGE: assert property (@(posedge CLK) disable iff (RST)
        pcl_write |=> (pc_reg[7:0] == $past(pcl_wdata) &&
                       pc_reg[PC_WIDTH-1:8] == $past(pc_reg[PC_WIDTH-1:8])))
        else $error("Low byte jump left the page");
endmodule // dmb_pc_low

/* File: dmb_pkg.sv */
// Constants for the data memory bank and indirect access block.
// Assumes a single core clock; the execution unit drives one access a cycle.
// What this block does
// - Special registers sit in data memory from address zero upward.
// - Unused locations between special and general memory read as zero.
// - Naming a window register acts on the location its pointer holds.
// - Window zero reaches bank 0 only; window one reaches banks 0 and 1.
// - A pointer aimed at a window reads zero and ignores writes.
// - Both pointers are real registers, readable and writable.
// - Small variants ignore pointer bit 7 and read it back as one.
// - Bank pointer value 00 selects bank 0, value 01 bank 1.
// - Window zero always targets bank 0 whatever the bank pointer holds.
// - Bank 1 holds only the EEPROM control register.
// - EEPROM control at 40H bank 1, reached via window one with bank 1.
// - Resets clear bank selection, except watchdog reset in power-down.
// - Special register area is decoded for direct access whatever the bank; window one in bank 1 does not reach it.
// - Direct addressed accesses always go to bank 0.
// - Accumulator takes ALU results; moves between registers pass through it.
// - Writing program counter low byte jumps within the current page.
// - Writing program counter low byte inserts one dummy cycle, unless the write lands in a dummy cycle.
package dmb_pkg;
    localparam logic [7:0] ADR_WIN0   = 8'h00;
    localparam logic [7:0] ADR_PTR0   = 8'h01;
    localparam logic [7:0] ADR_WIN1   = 8'h02;
    localparam logic [7:0] ADR_PTR1   = 8'h03;
    localparam logic [7:0] ADR_BANK   = 8'h04;
    localparam logic [7:0] ADR_ACC    = 8'h05;
    localparam logic [7:0] ADR_PCL    = 8'h06;
    localparam logic [7:0] ADR_EEPROM_CONTROL_WINDOW   = 8'h40;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    localparam logic [7:0] BANK0_VAL  = 8'h00;
    localparam logic [7:0] BANK1_VAL  = 8'h01;
    localparam logic [7:0] PTR_TOPBIT = 8'h80;
    localparam int         TOP_BIT    = 7;
    typedef enum logic [1:0] {
        DMB_RUN   = 2'b00,
        DMB_DUMMY = 2'b01
    } dmb_state_t;
endpackage
